// ---- hdl/charger_status_pkg.sv ----
// Purpose: constants for the charger status and fault register bank
// Assumes: byte-wide registers read over the two-wire serial port
// Notes: all status fields are live, read-only and reset to zero

package charger_status_pkg;

	localparam int REG_W = 8;
	localparam int NUM_REGS = 4;
	localparam int STATUS_W = REG_W * NUM_REGS;

	// register offsets
	localparam logic [7:0] OFS_CHARGER_STATUS_THREE = 8'h1E;
	localparam logic [7:0] OFS_CHARGER_STATUS_FOUR = 8'h1F;
	localparam logic [7:0] OFS_FAULT_STATUS_ZERO = 8'h20;
	localparam logic [7:0] OFS_FAULT_STATUS_ONE = 8'h21;

	localparam logic [REG_W-1:0] REG_RESET = 8'h00;

	// implemented-bit masks; reserved positions read zero
	localparam logic [REG_W-1:0] MASK_STATUS_THREE = 8'hFE;
	localparam logic [REG_W-1:0] MASK_STATUS_FOUR = 8'h1F;
	localparam logic [REG_W-1:0] MASK_FAULT_ZERO = 8'hFF;
	localparam logic [REG_W-1:0] MASK_FAULT_ONE = 8'hF4;

	// byte lanes of the packed status vector
	localparam int LANE_STATUS_THREE = 0;
	localparam int LANE_STATUS_FOUR = 8;
	localparam int LANE_FAULT_ZERO = 16;
	localparam int LANE_FAULT_ONE = 24;

	// status three fields
	localparam int BIT_INPUT2_FET = 7;
	localparam int BIT_INPUT1_FET = 6;
	localparam int BIT_ADC_DONE = 5;
	localparam int BIT_MIN_SYS_REG = 4;
	localparam int BIT_FAST_TMR = 3;
	localparam int BIT_TRICKLE_TMR = 2;
	localparam int BIT_PRECHG_TMR = 1;
	// status four fields
	localparam int BIT_BATT_LOW_BOOST = 4;
	localparam int BIT_TS_COLD = 3;
	localparam int BIT_TS_COOL = 2;
	localparam int BIT_TS_WARM = 1;
	localparam int BIT_TS_HOT = 0;
	// fault zero fields
	localparam int BIT_DISCHG_REG = 7;
	localparam int BIT_BUS_OV = 6;
	localparam int BIT_BAT_OV = 5;
	localparam int BIT_BUS_OC = 4;
	localparam int BIT_BAT_OC = 3;
	localparam int BIT_CONV_OC = 2;
	localparam int BIT_AD2_OV = 1;
	localparam int BIT_AD1_OV = 0;
	// fault one fields
	localparam int BIT_SYS_SHORT = 7;
	localparam int BIT_SYS_OV = 6;
	localparam int BIT_BOOST_OV = 5;
	localparam int BIT_BOOST_UV = 4;
	localparam int BIT_TSHUT = 2;

	// synchroniser vector layout above the status lanes
	localparam int SYNC_ONE_SHOT = 32;
	localparam int SYNC_FORWARD = 33;
	localparam int SYNC_SCL = 34;
	localparam int SYNC_SDA = 35;
	localparam int SYNC_W = 36;

	// serial port
	localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2A; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b0_0001,
		ST_RX = 5'b0_0010,
		ST_ACK = 5'b0_0100,
		ST_TX = 5'b0_1000,
		ST_MACK = 5'b1_0000
	} port_state_t;

endpackage : charger_status_pkg

// ---- hdl/sync_if.sv ----
// Purpose: carries raw and synchronised levels between bank and synchroniser
// Assumes: one clock domain on the synchronised side
// Notes: raw side is asynchronous

`timescale 1ns/1ps

interface sync_if import charger_status_pkg::*; ();
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] synced;
	modport src (output raw, input synced);
	modport sync (input raw, output synced);
endinterface : sync_if

// ---- hdl/level_sync.sv ----
// Purpose: two-flop synchroniser for all asynchronous level inputs
// Assumes: inputs are slow levels from analog detectors and the serial pins
// Notes: first stage feeds only the second stage

`timescale 1ns/1ps

module level_sync import charger_status_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	sync_if.sync port
);

	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] stable_q;

	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					stable_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= port.raw[i];
					stable_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign port.synced = stable_q;

endmodule : level_sync

// ---- hdl/charger_status_regs.sv ----
// Purpose: charger status and fault registers behind the serial target port
// Assumes: detector outputs are asynchronous levels, active high
// Notes: registers are live snapshots; a read byte is frozen while shifted out

`timescale 1ns/1ps

module charger_status_regs import charger_status_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic input2BlockingFetPresent,
	input wire logic input1BlockingFetPresent,
	input wire logic adcConversionDone,
	input wire logic adcOneShotMode,
	input wire logic minSystemRegulationActive,
	input wire logic forwardMode,
	input wire logic fastChargeTimerExpired,
	input wire logic trickleTimerExpired,
	input wire logic prechargeTimerExpired,
	input wire logic batteryTooLowForBoost,
	input wire logic thermistorColdZone,
	input wire logic thermistorCoolZone,
	input wire logic thermistorWarmZone,
	input wire logic thermistorHotZone,
	input wire logic dischargeCurrentRegulation,
	input wire logic inputBusOvervoltage,
	input wire logic batteryOvervoltage,
	input wire logic inputBusOvercurrent,
	input wire logic batteryOvercurrent,
	input wire logic converterOvercurrent,
	input wire logic adapter2Overvoltage,
	input wire logic adapter1Overvoltage,
	input wire logic systemRailShort,
	input wire logic systemRailOvervoltage,
	input wire logic boostOutputOvervoltage,
	input wire logic boostOutputUndervoltage,
	input wire logic thermalShutdownActive,
	output logic [STATUS_W-1:0] statusView
);

	////////////////////////////////////////////////////////////////////////
	// synchronise every asynchronous level

	sync_if syncPort ();

	always_comb begin
		syncPort.raw = '0;
		syncPort.raw[LANE_STATUS_THREE+BIT_INPUT2_FET] =
			input2BlockingFetPresent;
		syncPort.raw[LANE_STATUS_THREE+BIT_INPUT1_FET] =
			input1BlockingFetPresent;
		syncPort.raw[LANE_STATUS_THREE+BIT_ADC_DONE] = adcConversionDone;
		syncPort.raw[LANE_STATUS_THREE+BIT_MIN_SYS_REG] =
			minSystemRegulationActive;
		syncPort.raw[LANE_STATUS_THREE+BIT_FAST_TMR] = fastChargeTimerExpired;
		syncPort.raw[LANE_STATUS_THREE+BIT_TRICKLE_TMR] = trickleTimerExpired;
		syncPort.raw[LANE_STATUS_THREE+BIT_PRECHG_TMR] = prechargeTimerExpired;
		syncPort.raw[LANE_STATUS_FOUR+BIT_BATT_LOW_BOOST] =
			batteryTooLowForBoost;
		syncPort.raw[LANE_STATUS_FOUR+BIT_TS_COLD] = thermistorColdZone;
		syncPort.raw[LANE_STATUS_FOUR+BIT_TS_COOL] = thermistorCoolZone;
		syncPort.raw[LANE_STATUS_FOUR+BIT_TS_WARM] = thermistorWarmZone;
		syncPort.raw[LANE_STATUS_FOUR+BIT_TS_HOT] = thermistorHotZone;
		syncPort.raw[LANE_FAULT_ZERO+BIT_DISCHG_REG] =
			dischargeCurrentRegulation;
		syncPort.raw[LANE_FAULT_ZERO+BIT_BUS_OV] =
			inputBusOvervoltage;
		syncPort.raw[LANE_FAULT_ZERO+BIT_BAT_OV] =
			batteryOvervoltage;
		syncPort.raw[LANE_FAULT_ZERO+BIT_BUS_OC] =
			inputBusOvercurrent;
		syncPort.raw[LANE_FAULT_ZERO+BIT_BAT_OC] =
			batteryOvercurrent;
		syncPort.raw[LANE_FAULT_ZERO+BIT_CONV_OC] =
			converterOvercurrent;
		syncPort.raw[LANE_FAULT_ZERO+BIT_AD2_OV] =
			adapter2Overvoltage;
		syncPort.raw[LANE_FAULT_ZERO+BIT_AD1_OV] =
			adapter1Overvoltage;
		syncPort.raw[LANE_FAULT_ONE+BIT_SYS_SHORT] =
			systemRailShort;
		syncPort.raw[LANE_FAULT_ONE+BIT_SYS_OV] =
			systemRailOvervoltage;
		syncPort.raw[LANE_FAULT_ONE+BIT_BOOST_OV] =
			boostOutputOvervoltage;
		syncPort.raw[LANE_FAULT_ONE+BIT_BOOST_UV] =
			boostOutputUndervoltage;
		syncPort.raw[LANE_FAULT_ONE+BIT_TSHUT] =
			thermalShutdownActive;
		syncPort.raw[SYNC_ONE_SHOT] = adcOneShotMode;
		syncPort.raw[SYNC_FORWARD] = forwardMode;
		// pins pass inverted, so cleared syncs read as an idle bus
		syncPort.raw[SYNC_SCL] = ~sclIn;
		syncPort.raw[SYNC_SDA] = ~sdaIn;
	end

	level_sync u_level_sync (
		.core_clk(core_clk),
		.rst(rst),
		.port(syncPort)
	);

	////////////////////////////////////////////////////////////////////////
	// live status bank

	logic [STATUS_W-1:0] status_q;
	logic [STATUS_W-1:0] status_d;
	logic [STATUS_W-1:0] syncBits;

	assign syncBits = syncPort.synced[STATUS_W-1:0];

	always_comb begin
		status_d = syncBits;
		// conversion-done means nothing outside one-shot mode
		status_d[LANE_STATUS_THREE+BIT_ADC_DONE] =
			syncBits[LANE_STATUS_THREE+BIT_ADC_DONE] &
			syncPort.synced[SYNC_ONE_SHOT];
		status_d[LANE_STATUS_THREE+BIT_MIN_SYS_REG] =
			syncBits[LANE_STATUS_THREE+BIT_MIN_SYS_REG] &
			syncPort.synced[SYNC_FORWARD];
		// reserved positions forced low regardless of the vector
		status_d[LANE_STATUS_THREE+:REG_W] =
			status_d[LANE_STATUS_THREE+:REG_W] & MASK_STATUS_THREE;
		status_d[LANE_STATUS_FOUR+:REG_W] =
			status_d[LANE_STATUS_FOUR+:REG_W] & MASK_STATUS_FOUR;
		status_d[LANE_FAULT_ZERO+:REG_W] =
			status_d[LANE_FAULT_ZERO+:REG_W] & MASK_FAULT_ZERO;
		status_d[LANE_FAULT_ONE+:REG_W] =
			status_d[LANE_FAULT_ONE+:REG_W] & MASK_FAULT_ONE;
	end

	// no latching: each cycle replaces the previous condition
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_q <= {NUM_REGS{REG_RESET}};
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			statusView <= {NUM_REGS{REG_RESET}};
		end else begin
			statusView <= status_d;
		end
	end

	// unmapped offsets read zero
	function automatic logic [REG_W-1:0] readReg(
		input logic [7:0] ofs,
		input logic [STATUS_W-1:0] bank
	);
		case (ofs)
			OFS_CHARGER_STATUS_THREE: readReg = bank[LANE_STATUS_THREE+:REG_W];
			OFS_CHARGER_STATUS_FOUR: readReg = bank[LANE_STATUS_FOUR+:REG_W];
			OFS_FAULT_STATUS_ZERO: readReg = bank[LANE_FAULT_ZERO+:REG_W];
			OFS_FAULT_STATUS_ONE: readReg = bank[LANE_FAULT_ONE+:REG_W];
			default: readReg = REG_RESET;
		endcase
	endfunction : readReg

	////////////////////////////////////////////////////////////////////////
	// serial line conditions

	logic sclS;
	logic sdaS;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclS = ~syncPort.synced[SYNC_SCL];
	assign sdaS = ~syncPort.synced[SYNC_SDA];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	assign sclRise = sclS & ~sclPrev_q;
	assign sclFall = ~sclS & sclPrev_q;
	assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
	assign stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

	////////////////////////////////////////////////////////////////////////
	// target state machine

	port_state_t state_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic addrByte_q;
	logic ptrByte_q;
	logic readDir_q;
	logic [REG_W-1:0] readByte;

	// byte under the pointer, loaded whole before it is shifted out
	assign readByte = readReg(ptr_q, status_q);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bitCnt_q <= '0;
			shift_q <= '0;
			ptr_q <= '0;
			addrByte_q <= 1'b0;
			ptrByte_q <= 1'b0;
			readDir_q <= 1'b0;
			sdaOe <= 1'b0;
		end else if (startSeen) begin
			// repeated start keeps the pointer
			state_q <= ST_RX;
			bitCnt_q <= '0;
			addrByte_q <= 1'b1;
			ptrByte_q <= 1'b0;
			sdaOe <= 1'b0;
		end else if (stopSeen) begin
			state_q <= ST_IDLE;
			sdaOe <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sdaOe <= 1'b0;
				end
				ST_RX: begin
					if (sclRise) begin
						shift_q <= {shift_q[6:0], sdaS};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
						if (addrByte_q && shift_q[7:1] != TARGET_ADDR) begin
							state_q <= ST_IDLE;
						end else begin
							if (addrByte_q) begin
								readDir_q <= shift_q[0];
							end else if (ptrByte_q) begin
								ptr_q <= shift_q;
							end
							// data bytes are acknowledged but not stored
							state_q <= ST_ACK;
							sdaOe <= 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						bitCnt_q <= '0;
						addrByte_q <= 1'b0;
						ptrByte_q <= addrByte_q & ~readDir_q;
						if (addrByte_q && readDir_q) begin
							shift_q <= readByte;
							sdaOe <= ~readByte[7];
							state_q <= ST_TX;
						end else begin
							sdaOe <= 1'b0;
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclFall) begin
						if (bitCnt_q == LAST_TX_BIT) begin
							sdaOe <= 1'b0;
							ptr_q <= ptr_q + 8'h01;
							state_q <= ST_MACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sdaOe <= ~shift_q[6];
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (sclRise && sdaS) begin
						// not-acknowledge ends the read burst
						state_q <= ST_IDLE;
					end else if (sclFall) begin
						bitCnt_q <= '0;
						shift_q <= readByte;
						sdaOe <= ~readByte[7];
						state_q <= ST_TX;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

endmodule : charger_status_regs

// ---- bench/charger_status_props.sv ----
// Purpose: port-level checks for the charger status register bank
// Assumes: a detector level reaches statusView three clocks later
// Notes: settle_q masks the first edges after reset, syncs still empty
`timescale 1ns/1ps
module charger_status_props import charger_status_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sdaOe,
	input wire logic input2BlockingFetPresent,
	input wire logic adcConversionDone,
	input wire logic adcOneShotMode,
	input wire logic minSystemRegulationActive,
	input wire logic forwardMode,
	input wire logic fastChargeTimerExpired,
	input wire logic batteryTooLowForBoost,
	input wire logic thermistorHotZone,
	input wire logic inputBusOvervoltage,
	input wire logic thermalShutdownActive,
	input wire logic [STATUS_W-1:0] statusView
);
	localparam logic [31:0] RSV = ~{MASK_FAULT_ONE, MASK_FAULT_ZERO,
		MASK_STATUS_FOUR, MASK_STATUS_THREE};
	logic [1:0] settle_q;
	logic settled;
	assign settled = (settle_q == 2'h3);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			settle_q <= 2'h0;
		end else if (!settled) begin
			settle_q <= settle_q + 2'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	chk_fet_bits: assert property (
		settled |-> statusView[7] == $past(input2BlockingFetPresent, 3))
		else $error("fet bit wrong");
	chk_adc_gate: assert property (
		settled |-> statusView[5] ==
		($past(adcConversionDone, 3) & $past(adcOneShotMode, 3)))
		else $error("adc done bit wrong");
	chk_minsys_gate: assert property (
		settled |-> statusView[4] ==
		($past(minSystemRegulationActive, 3) & $past(forwardMode, 3)))
		else $error("min system bit wrong");
	chk_fast_timer: assert property (
		settled |-> statusView[3] == $past(fastChargeTimerExpired, 3))
		else $error("timer bit wrong");
	chk_boost_low: assert property (
		settled |-> statusView[12] == $past(batteryTooLowForBoost, 3))
		else $error("boost low bit wrong");
	chk_hot_zone: assert property (
		settled |-> statusView[8] == $past(thermistorHotZone, 3))
		else $error("hot zone bit wrong");
	chk_bus_ov: assert property (
		settled |-> statusView[22] == $past(inputBusOvervoltage, 3))
		else $error("bus over-voltage bit wrong");
	chk_tshut_bit: assert property (
		settled |-> statusView[26] == $past(thermalShutdownActive, 3))
		else $error("shutdown bit wrong");
	chk_reserved_zero: assert property (
		(statusView & RSV) == 32'h0000_0000)
		else $error("reserved bit set");
	chk_reset_clear: assert property (
		$past(rst) |-> statusView == 32'h0000_0000 && !sdaOe)
		else $error("not clear after reset");
	cover property (statusView[5]);
	cover property (sdaOe);
	cover property (statusView[26] && statusView[8]);
endmodule : charger_status_props
bind charger_status_regs charger_status_props charger_status_props_i (
	.core_clk(core_clk),
	.rst(rst),
	.sdaOe(sdaOe),
	.input2BlockingFetPresent(input2BlockingFetPresent),
	.adcConversionDone(adcConversionDone),
	.adcOneShotMode(adcOneShotMode),
	.minSystemRegulationActive(minSystemRegulationActive),
	.forwardMode(forwardMode),
	.fastChargeTimerExpired(fastChargeTimerExpired),
	.batteryTooLowForBoost(batteryTooLowForBoost),
	.thermistorHotZone(thermistorHotZone),
	.inputBusOvervoltage(inputBusOvervoltage),
	.thermalShutdownActive(thermalShutdownActive),
	.statusView(statusView)
);

// ---- bench/i2c_host_model.sv ----
// Purpose: two-wire host that reads and writes the status bank
// Assumes: phases of 8 core clocks, above the 5-clock minimum
// Notes: data moves two clocks after the clock falls, to keep hold time
`timescale 1ns/1ps
module i2c_host_model (
	input wire logic core_clk,
	input wire logic sdaWire,
	output logic sclOut,
	output logic sdaLow,
	output logic rdValid,
	output logic [7:0] rdByte
);
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
		rdValid = 1'b0;
		rdByte = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic half();
		repeat (8) @(negedge core_clk);
	endtask : half
	task automatic bitIo(input logic b, output logic r);
		repeat (2) @(negedge core_clk);
		sdaLow = !b;
		half();
		sclOut = 1'b1;
		half();
		r = sdaWire;
		sclOut = 1'b0;
	endtask : bitIo
	task automatic byteIo(input logic [7:0] tx, input logic ackIn,
		output logic [7:0] rx, output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bitIo(tx[i], rx[i]);
		end
		bitIo(ackIn, ackOut);
	endtask : byteIo
	// also serves as repeated start: line released before the clock rises
	task automatic start();
		repeat (2) @(negedge core_clk);
		sdaLow = 1'b0;
		half();
		sclOut = 1'b1;
		half();
		sdaLow = 1'b1;
		half();
		sclOut = 1'b0;
	endtask : start
	task automatic stop();
		repeat (2) @(negedge core_clk);
		sdaLow = 1'b1;
		half();
		sclOut = 1'b1;
		half();
		sdaLow = 1'b0;
		half();
	endtask : stop
	task automatic post(input logic [7:0] b);
		rdByte = b;
		rdValid = 1'b1;
		@(negedge core_clk);
		rdValid = 1'b0;
	endtask : post
	task automatic probe(input logic [6:0] a);
		logic [7:0] rx;
		logic ack;
		start();
		byteIo({a, 1'b0}, 1'b1, rx, ack);
		stop();
		post({7'h00, ack});
	endtask : probe
	task automatic writeReg(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d);
		logic [7:0] rx;
		logic ack;
		start();
		byteIo({a, 1'b0}, 1'b1, rx, ack);
		byteIo(p, 1'b1, rx, ack);
		byteIo(d, 1'b1, rx, ack);
		stop();
	endtask : writeReg
	task automatic readRegs(input logic [6:0] a, input logic [7:0] p,
		input int n);
		logic [7:0] rx;
		logic ack;
		start();
		byteIo({a, 1'b0}, 1'b1, rx, ack);
		byteIo(p, 1'b1, rx, ack);
		start();
		byteIo({a, 1'b1}, 1'b1, rx, ack);
		for (int i = 0; i < n; i++) begin
			byteIo(8'hFF, (i == n - 1), rx, ack);
			post(rx);
		end
		stop();
	endtask : readRegs
endmodule : i2c_host_model

// ---- bench/charger_status_regs_tb_top.sv ----
// Purpose: self-checking bench for the charger status register bank
// Assumes: the host model reads the bank over the two-wire port
// Notes: det mirrors statusView lanes, so expectations are a mask away
`timescale 1ns/1ps
`define CHK(a, b) begin \
	samplesChecked++; \
	if ((a) !== (b)) begin \
		miscompares++; \
		$display("unexpected at %0t: got %0h want %0h", $time, a, b); \
	end \
end
module charger_status_regs_tb_top import charger_status_pkg::*; ();
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic adcOneShotMode = 1'b1;
	logic forwardMode = 1'b1;
	logic [31:0] det = '1;
	logic [31:0] rv;
	logic [1:0] rg;
	logic sclOut, sdaLow, rdValid, sdaOut, sdaOe;
	logic [7:0] rdByte, expByte;
	logic [STATUS_W-1:0] statusView;
	wire sdaWire = (sdaOe ? sdaOut : 1'b1) && !sdaLow;
	logic [7:0] expQ[$];
	int miscompares = 0;
	int samplesChecked = 0;
	always #4 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////
	charger_status_regs charger_status_regs_i (.core_clk(core_clk),
		.rst(rst), .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .input2BlockingFetPresent(det[7]),
		.input1BlockingFetPresent(det[6]), .adcConversionDone(det[5]),
		.adcOneShotMode(adcOneShotMode), .forwardMode(forwardMode),
		.minSystemRegulationActive(det[4]), .fastChargeTimerExpired(det[3]),
		.trickleTimerExpired(det[2]), .prechargeTimerExpired(det[1]),
		.batteryTooLowForBoost(det[12]), .thermistorColdZone(det[11]),
		.thermistorCoolZone(det[10]), .thermistorWarmZone(det[9]),
		.thermistorHotZone(det[8]), .dischargeCurrentRegulation(det[23]),
		.inputBusOvervoltage(det[22]), .batteryOvervoltage(det[21]),
		.inputBusOvercurrent(det[20]), .batteryOvercurrent(det[19]),
		.converterOvercurrent(det[18]), .adapter2Overvoltage(det[17]),
		.adapter1Overvoltage(det[16]), .systemRailShort(det[31]),
		.systemRailOvervoltage(det[30]), .boostOutputOvervoltage(det[29]),
		.boostOutputUndervoltage(det[28]), .thermalShutdownActive(det[26]),
		.statusView(statusView));
	i2c_host_model i2c_host_model_i (.core_clk(core_clk),
		.sdaWire(sdaWire), .sclOut(sclOut), .sdaLow(sdaLow),
		.rdValid(rdValid), .rdByte(rdByte));
	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		if (rdValid) begin
			expByte = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
			`CHK(rdByte, expByte)
		end
	end
	function automatic logic [31:0] expView(logic [31:0] d, logic os,
		logic fw);
		logic [31:0] v;
		v = d & {MASK_FAULT_ONE, MASK_FAULT_ZERO, MASK_STATUS_FOUR,
			MASK_STATUS_THREE};
		v[BIT_ADC_DONE] = v[BIT_ADC_DONE] & os;
		v[BIT_MIN_SYS_REG] = v[BIT_MIN_SYS_REG] & fw;
		return v;
	endfunction : expView
	task automatic setDet(input logic [31:0] d, input logic os,
		input logic fw);
		@(negedge core_clk);
		det = d;
		adcOneShotMode = os;
		forwardMode = fw;
		repeat (4) @(negedge core_clk);
		`CHK(statusView, expView(d, os, fw))
	endtask : setDet
	// notes every byte first, since results arrive while the host runs
	task automatic readRegs(input logic [7:0] p, input int n);
		logic [31:0] v;
		logic [7:0] o;
		v = expView(det, adcOneShotMode, forwardMode);
		for (int i = 0; i < n; i++) begin
			o = p + 8'(i);
			expQ.push_back((o >= 8'h1E && o <= 8'h21) ?
				v[(o - 8'h1E) * 8 +: 8] : 8'h00);
		end
		i2c_host_model_i.readRegs(TARGET_ADDR_DEFAULT, p, n);
	endtask : readRegs
	task automatic completeRun();
		$display("checked %0d, unexpected %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : completeRun
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6df4));
		repeat (5) @(negedge core_clk);
		`CHK(statusView, 32'h0000_0000)
		rst = 1'b0;
		$display("test reset done");
		for (int i = 0; i < 32; i++) begin
			setDet(32'h0000_0001 << i, 1'b1, 1'b1);
		end
		for (int g = 0; g < 4; g++) begin
			setDet('1, g[0], g[1]);
		end
		$display("test bit map done");
		for (int k = 0; k < 4; k++) begin
			rv = $urandom;
			rg = 2'($urandom);
			setDet(rv, rg[0], rg[1]);
			readRegs(8'h1E, 4);
		end
		$display("test burst read done");
		readRegs(8'h21, 2);
		i2c_host_model_i.writeReg(TARGET_ADDR_DEFAULT, 8'h20, 8'h5A);
		readRegs(8'h20, 1);
		$display("test write and unmapped done");
		expQ.push_back(8'h01);
		i2c_host_model_i.probe(TARGET_ADDR_DEFAULT ^ 7'h01);
		expQ.push_back(8'h00);
		i2c_host_model_i.probe(TARGET_ADDR_DEFAULT);
		$display("test address refusal done");
		`CHK(expQ.size(), 0)
		completeRun();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		completeRun();
	end
endmodule : charger_status_regs_tb_top
